// >>> tb_tmc_regs.sv
// self-checking bench for the tx monitor and rate control register bank
`timescale 1ns/1ps
module tb_tmc_regs;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} tmc_row_s;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, bf, pf, tm, fde, fle, irq, cv = 1'b0;
  logic [7:0] adr, bc = 8'h00, pc = 8'h00;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  logic bs = 1'b0, ps = 1'b0, bp = 1'b0, pp = 1'b0, fda = 1'b0, lk = 1'b0;
  logic [9:0] cd = 10'h000;
  logic [1:0] mo;
  logic [2:0] dv;
  int miscompares = 0, tests_run = 0, cycles = 0;
  tmc_row_s rows [8] = '{'{8'h44, 8'hA5, 8'hA5}, '{8'h48, 8'h5A, 8'h5A}, '{8'h4C, 8'h47, 8'h47},
    '{8'h50, 8'hFF, 8'h00}, '{8'h9C, 8'hFF, 8'h00}, '{8'hA0, 8'hFF, 8'h00}, '{8'hA4, 8'hFF, 8'h00},
    '{8'hFC, 8'hFF, 8'h00}};
  always #5 clk_i = ~clk_i;
  tmc_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));
  tmc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .bias_current_i(bc), .pd_current_i(pc),
    .bias_monitor_pin_i(bp), .pd_monitor_pin_i(pp), .digital_bias_monitor_select_i(bs),
    .digital_pd_monitor_select_i(ps), .fd_auto_enable_i(fda), .cdr_lock_status_i(lk), .driver_disabled_i(1'b0),
    .conv_valid_i(cv), .conv_data_i(cd), .bias_fault_o(bf), .power_fault_o(pf), .rate_detect_mode_o(mo),
    .rate_test_mode_o(tm), .freq_detector_enable_o(fde), .fast_lock_en_o(fle), .rate_divider_select_o(dv),
    .irq_o(irq));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host.xfer(1'b0, a, 8'h00, d);
  endtask
  task automatic mon(input logic s1, input logic [7:0] c1, input logic p1, input logic s2, input logic [7:0] c2,
    input logic p2, input logic e1, input logic e2);
    @(posedge clk_i);
    bs <= s1;
    bc <= c1;
    bp <= p1;
    ps <= s2;
    pc <= c2;
    pp <= p2;
    tick(4);
    chk(32'(bf), 32'(e1));
    chk(32'(pf), 32'(e2));
  endtask
  task automatic fd(input logic [7:0] v, input logic au, input logic e);
    @(posedge clk_i);
    fda <= au;
    wr(8'h4C, v);
    tick(1);
    chk(32'(fde), 32'(e));
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    tick(5);
    rst_i <= 1'b0;
    chk({mo, dv, fle, fde, tm, irq}, 32'h008);
    for (int i = 0; i < 3; i++) begin
      rd(8'h44 + 8'(4 * i), r);
      chk(r, 32'h0);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, r);
      chk(r, 32'(rows[i].e));
    end
    $display("test register table done");
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 6; d++) begin
        wr(8'h4C, {2'(m), 3'h0, 3'(d)});
        tick(1);
        chk({tm, mo, dv}, 32'({1'b0, 2'(m), 3'(d)}));
      end
    end
    wr(8'h4C, 8'h07);
    tick(1);
    chk(32'(dv), 32'h0);
    wr(8'h4C, 8'h08);
    tick(1);
    chk(32'(fle), 32'h0);
    fd(8'h20, 1'b0, 1'b1);
    fd(8'h10, 1'b1, 1'b0);
    fd(8'h30, 1'b1, 1'b0);
    fd(8'h00, 1'b1, 1'b1);
    chk(32'(fle), 32'h1);
    $display("test rate control done");
    wr(8'h44, 8'h80);
    wr(8'h48, 8'h40);
    mon(1'b1, 8'h7F, 1'b1, 1'b1, 8'h3F, 1'b1, 1'b0, 1'b0);
    mon(1'b1, 8'h80, 1'b0, 1'b1, 8'h40, 1'b0, 1'b1, 1'b1);
    mon(1'b0, 8'hFF, 1'b0, 1'b0, 8'hFF, 1'b0, 1'b0, 1'b0);
    mon(1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1);
    mon(1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
    $display("test monitors done");
    chk(32'(irq), 32'h0);
    wr(8'hF4, 8'h01);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(8'hF0, 8'h01);
    tick(2);
    chk(32'(irq), 32'h0);
    rd(8'hF0, r);
    chk(r & 32'h3, 32'h2);
    $display("test interrupts done");
    @(posedge clk_i);
    cv <= 1'b1;
    cd <= 10'h2B7;
    @(posedge clk_i);
    cv <= 1'b0;
    tick(1);
    rd(8'hA0, r);
    chk(r, 32'hAD);
    @(posedge clk_i);
    cv <= 1'b1;
    cd <= 10'h001;
    @(posedge clk_i);
    cv <= 1'b0;
    tick(1);
    rd(8'hA4, r);
    chk(r, 32'h3);
    $display("test converter done");
    @(posedge clk_i);
    lk <= 1'b1;
    tick(2);
    rd(8'hAC, r);
    rd(8'hAC, r);
    chk(r & 32'hC0, 32'hC0);
    lk <= 1'b0;
    tick(2);
    lk <= 1'b1;
    tick(2);
    rd(8'hAC, r);
    chk(r & 32'hC0, 32'h80);
    rd(8'hAC, r);
    chk(r & 32'hC0, 32'hC0);
    $display("test lock status done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    rd(8'h44, r);
    chk(r, 32'h0);
    chk(32'(fle), 32'h1);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule

// >>> tmc_fault_mon.sv
// one threshold fault monitor, digital compare or analog comparator path
`timescale 1ns/1ps
module tmc_fault_mon #(
  parameter int unsigned THR_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             digital_sel_i,
  input  wire logic [THR_W-1:0] current_i,
  input  wire logic [THR_W-1:0] threshold_i,
  input  wire logic             analog_fault_i,
  output logic                  fault_o
);
  initial begin
    if (THR_W < 1) $error("threshold width must be at least one");
  end

  // threshold only counts when the digital path is chosen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if (ce_i) begin
      fault_o <= digital_sel_i ? (current_i >= threshold_i) : analog_fault_i;
    end
  end
endmodule

// >>> tmc_host.sv
// wishbone classic master standing in for the management microcontroller
`timescale 1ns/1ps
module tmc_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    rd = 32'hXXXXXXXX;
    if (w && a == 8'h4C && wd[7:6] == 2'h3) wd[7:6] = 2'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= {24'h000000, wd};
    // no limit here: only the bench timeout ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released data lines must not look still valid
    dat_o <= ~dat_o;
  endtask
endmodule

// >>> tmc_pkg.sv
// shared constants for the tx monitor and cdr control register bank
package tmc_pkg;
  localparam int unsigned REG_W   = 8;
  localparam int unsigned IDX_W   = 6;
  localparam int unsigned ADR_W   = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BIAS_THR    = 6'h11;
  localparam logic [5:0] IDX_PWR_THR     = 6'h12;
  localparam logic [5:0] IDX_RATE_CTRL   = 6'h13;
  localparam logic [5:0] IDX_RSVD_FIRST  = 6'h14;
  localparam logic [5:0] IDX_RSVD_LAST   = 6'h27;
  localparam logic [5:0] IDX_CONV_HIGH   = 6'h28;
  localparam logic [5:0] IDX_CONV_LOW    = 6'h29;
  localparam logic [5:0] IDX_LOCK_STAT   = 6'h2B;
  localparam logic [5:0] IDX_IRQ_STAT    = 6'h3C;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h3D;

  // rate_detect_control fields
  localparam int unsigned RC_MODE_LSB    = 6;
  localparam int unsigned RC_FORCE_ON    = 5;
  localparam int unsigned RC_FORCE_OFF   = 4;
  localparam int unsigned RC_FL_OFF      = 3;
  localparam int unsigned RC_DIV_LSB     = 0;

  localparam logic [1:0] MODE_AUTO       = 2'h0;
  localparam logic [1:0] MODE_FIX_10G3   = 2'h1;
  localparam logic [1:0] MODE_FIX_11G1   = 2'h2;
  localparam logic [1:0] MODE_TEST       = 2'h3;
  localparam logic [2:0] DIV_MAX_CODE    = 3'h5;

  // lock_fault_status fields
  localparam int unsigned LS_RAW         = 7;
  localparam int unsigned LS_LATCHED     = 6;
  localparam int unsigned LS_FAULT       = 5;
  localparam int unsigned LS_DRV_DIS     = 4;

  // interrupt status bits
  localparam int unsigned IRQ_N          = 4;
  localparam int unsigned IRQ_BIAS       = 0;
  localparam int unsigned IRQ_PWR        = 1;
  localparam int unsigned IRQ_UNLOCK     = 2;
  localparam int unsigned IRQ_CONV       = 3;

  localparam logic [7:0] RST_REG         = 8'h00;
  localparam logic [9:0] RST_CONV        = 10'h000;
  localparam logic [3:0] RST_IRQ         = 4'h0;
endpackage

// >>> tmc_regs.sv
// tx monitor thresholds, rate detect control, converter result and lock status bank
// Notes on behaviour
// - digital bias monitor faults when bias current reaches the bias threshold
// - digital photodiode monitor faults when photodiode current reaches the power threshold
// - mode code: 00 auto, 01 fixed 10.3G, 10 fixed 11.1G, 11 test
// - force-on bit keeps the frequency detector enabled unless force-off is set, else automatic
// - force-off bit keeps the frequency detector disabled, else automatic
// - fast lock runs while its disable bit is 0, off when 1
// - divider code 000 full rate, 001..101 divide by 2 to 32
// - reset clears threshold and rate control registers to zero
// - reserved range reads zero and ignores writes
// - converter bits 9:2 in high register, bits 1:0 in low register
// - low register upper six bits read zero; both results zero after reset
// - bias select 1 picks digital monitor, 0 the analog one
// - photodiode select 1 picks digital monitor, 0 the analog one
// - latched lock bit drops with raw status, holds, restored by read
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module tmc_regs #(
  parameter int unsigned CONV_W = 10
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  bias_current_i,
  input  wire logic [7:0]  pd_current_i,
  input  wire logic        bias_monitor_pin_i,
  input  wire logic        pd_monitor_pin_i,
  input  wire logic        digital_bias_monitor_select_i,
  input  wire logic        digital_pd_monitor_select_i,
  input  wire logic        fd_auto_enable_i,
  input  wire logic        cdr_lock_status_i,
  input  wire logic        driver_disabled_i,
  input  wire logic        conv_valid_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             bias_fault_o,
  output logic             power_fault_o,
  output logic [1:0]       rate_detect_mode_o,
  output logic             rate_test_mode_o,
  output logic             freq_detector_enable_o,
  output logic             fast_lock_en_o,
  output logic [2:0]       rate_divider_select_o,
  output logic             irq_o
);
  initial begin
    if (CONV_W != 10) $error("converter result layout serves only 10 bits");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [5:0] idx;
  logic       req;
  logic       wr_acc;
  logic       rd_acc;
  assign idx    = adr_i[7:2];
  assign req    = cyc_i && stb_i && !ack_o;
  // writes need lane 0 since every register sits in the low byte
  assign wr_acc = ce_i && req && we_i && sel_i[0];
  assign rd_acc = ce_i && req && !we_i;

  logic [7:0]        bias_thr_q;
  logic [7:0]        pwr_thr_q;
  logic [7:0]        rate_ctrl_q;
  logic [CONV_W-1:0] conv_q;
  logic [1:0]        conv_low_q;
  logic              conv_hold_q;
  logic              raw_q;
  logic              latched_q;
  logic [3:0]        irq_stat_q;
  logic [3:0]        irq_mask_q;
  logic [3:0]        irq_evt;
  logic [1:0]        fault;
  logic [1:0]        fault_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_thr_q  <= tmc_pkg::RST_REG;
      pwr_thr_q   <= tmc_pkg::RST_REG;
      rate_ctrl_q <= tmc_pkg::RST_REG;
    end else if (wr_acc) begin
      unique case (idx)
        tmc_pkg::IDX_BIAS_THR:  bias_thr_q  <= dat_i[7:0];
        tmc_pkg::IDX_PWR_THR:   pwr_thr_q   <= dat_i[7:0];
        tmc_pkg::IDX_RATE_CTRL: rate_ctrl_q <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= tmc_pkg::RST_IRQ;
    end else if (wr_acc && idx == tmc_pkg::IDX_IRQ_MASK) begin
      irq_mask_q <= dat_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge, one wait state
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      tmc_pkg::IDX_BIAS_THR:  rdata = bias_thr_q;
      tmc_pkg::IDX_PWR_THR:   rdata = pwr_thr_q;
      tmc_pkg::IDX_RATE_CTRL: rdata = rate_ctrl_q;
      tmc_pkg::IDX_CONV_HIGH: rdata = conv_q[9:2];
      tmc_pkg::IDX_CONV_LOW:  rdata = {6'h00, conv_low_q};
      tmc_pkg::IDX_LOCK_STAT: rdata = {raw_q, latched_q, fault[0] | fault[1], driver_disabled_i, 4'h0};
      tmc_pkg::IDX_IRQ_STAT:  rdata = {4'h0, irq_stat_q};
      tmc_pkg::IDX_IRQ_MASK:  rdata = {4'h0, irq_mask_q};
      default:                rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req;
      if (rd_acc) begin
        dat_o <= {24'h00_0000, rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter result with snapshot of the low bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_q <= tmc_pkg::RST_CONV;
    end else if (ce_i && conv_valid_i) begin
      conv_q <= conv_data_i;
    end
  end

  // held from the high-byte read until the low read, so no conversion tears the pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_hold_q <= 1'b0;
    end else if (rd_acc && idx == tmc_pkg::IDX_CONV_HIGH) begin
      conv_hold_q <= 1'b1;
    end else if (rd_acc && idx == tmc_pkg::IDX_CONV_LOW) begin
      conv_hold_q <= 1'b0;
    end
  end

  // low bits freeze at the high-byte read; the low read catches up with the latest result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_low_q <= 2'h0;
    end else if (rd_acc && idx == tmc_pkg::IDX_CONV_HIGH) begin
      conv_low_q <= conv_q[1:0];
    end else if (ce_i && conv_valid_i && (!conv_hold_q || (rd_acc && idx == tmc_pkg::IDX_CONV_LOW))) begin
      conv_low_q <= conv_data_i[1:0];
    end else if (rd_acc && idx == tmc_pkg::IDX_CONV_LOW) begin
      conv_low_q <= conv_q[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lock status: bit 7 is 1 while unlocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_q <= 1'b0;
    end else if (ce_i) begin
      raw_q <= cdr_lock_status_i;
    end
  end

  // a low raw level in the read cycle keeps the latch low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_q <= 1'b0;
    end else if (ce_i) begin
      if (!raw_q) begin
        latched_q <= 1'b0;
      end else if (rd_acc && idx == tmc_pkg::IDX_LOCK_STAT) begin
        latched_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault monitors
  logic [1:0] mon_sel;
  logic [7:0] mon_cur [2];
  logic [7:0] mon_thr [2];
  logic [1:0] mon_pin;
  assign mon_sel    = {digital_pd_monitor_select_i, digital_bias_monitor_select_i};
  assign mon_cur[0] = bias_current_i;
  assign mon_cur[1] = pd_current_i;
  assign mon_thr[0] = bias_thr_q;
  assign mon_thr[1] = pwr_thr_q;
  assign mon_pin    = {pd_monitor_pin_i, bias_monitor_pin_i};

  for (genvar g = 0; g < 2; g++) begin : g_mon
    tmc_fault_mon #(
      .THR_W(tmc_pkg::REG_W)
    ) u_mon (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .digital_sel_i  (mon_sel[g]),
      .current_i      (mon_cur[g]),
      .threshold_i    (mon_thr[g]),
      .analog_fault_i (mon_pin[g]),
      .fault_o        (fault[g])
    );
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_fault_o  <= 1'b0;
      power_fault_o <= 1'b0;
      fault_prev_q  <= 2'h0;
    end else if (ce_i) begin
      bias_fault_o  <= fault[0];
      power_fault_o <= fault[1];
      fault_prev_q  <= fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // rate detect and cdr controls
  logic [1:0] mode;
  logic       force_on;
  logic       force_off;
  assign mode      = rate_ctrl_q[tmc_pkg::RC_MODE_LSB +: 2];
  assign force_on  = rate_ctrl_q[tmc_pkg::RC_FORCE_ON];
  assign force_off = rate_ctrl_q[tmc_pkg::RC_FORCE_OFF];

  // software must keep off the test code; hardware only flags it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_detect_mode_o     <= tmc_pkg::MODE_AUTO;
      rate_test_mode_o       <= 1'b0;
      freq_detector_enable_o <= 1'b0;
      fast_lock_en_o         <= 1'b1;
      rate_divider_select_o  <= 3'h0;
    end else if (ce_i) begin
      rate_detect_mode_o     <= mode;
      rate_test_mode_o       <= (mode == tmc_pkg::MODE_TEST);
      // off wins a conflict: a stuck-on detector is the worse failure
      freq_detector_enable_o <= force_off ? 1'b0 : (force_on ? 1'b1 : fd_auto_enable_i);
      fast_lock_en_o         <= !rate_ctrl_q[tmc_pkg::RC_FL_OFF];
      // undefined codes 110 and 111 fall back to full rate
      rate_divider_select_o  <= (rate_ctrl_q[2:0] > tmc_pkg::DIV_MAX_CODE) ? 3'h0 : rate_ctrl_q[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  assign irq_evt[tmc_pkg::IRQ_BIAS]   = fault[0] && !fault_prev_q[0];
  assign irq_evt[tmc_pkg::IRQ_PWR]    = fault[1] && !fault_prev_q[1];
  assign irq_evt[tmc_pkg::IRQ_UNLOCK] = cdr_lock_status_i && !raw_q;
  assign irq_evt[tmc_pkg::IRQ_CONV]   = conv_valid_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= tmc_pkg::RST_IRQ;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      if (req && we_i && sel_i[0] && idx == tmc_pkg::IDX_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~dat_i[3:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read(logic [5:0] r);
    cyc_i && stb_i && !we_i && idx == r && ack_o;
  endsequence

  sequence s_read_any;
    cyc_i && stb_i && !we_i && ack_o;
  endsequence

  AST_BIAS_FAULT: assert property (ce_i && digital_bias_monitor_select_i && bias_current_i >= bias_thr_q
      |=> ##1 bias_fault_o) else $error("bias fault not raised at threshold");
  AST_PWR_ANALOG: assert property (ce_i && !digital_pd_monitor_select_i && !pd_monitor_pin_i
      |=> ##1 !power_fault_o) else $error("power fault without analog cause");
  AST_TEST_MODE: assert property (ce_i |=> rate_test_mode_o == ($past(mode) == tmc_pkg::MODE_TEST))
    else $error("test mode flag wrong");
  AST_FD_ON: assert property (ce_i && force_on && !force_off |=> freq_detector_enable_o)
    else $error("forced-on detector disabled");
  AST_FD_OFF: assert property (ce_i && force_off |=> !freq_detector_enable_o)
    else $error("forced-off detector enabled");
  AST_FAST_LOCK: assert property (ce_i |=> fast_lock_en_o != $past(rate_ctrl_q[tmc_pkg::RC_FL_OFF]))
    else $error("fast lock follows wrong level");
  AST_DIVIDER: assert property (ce_i && rate_ctrl_q[2:0] <= tmc_pkg::DIV_MAX_CODE
      |=> rate_divider_select_o == $past(rate_ctrl_q[2:0])) else $error("divider select mismatch");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=> bias_thr_q == 8'h00 && pwr_thr_q == 8'h00
      && rate_ctrl_q == 8'h00 && conv_q == 10'h000) else $error("registers not cleared by reset");
  AST_RSVD: assert property (s_read_any ##0 (idx >= tmc_pkg::IDX_RSVD_FIRST && idx <= tmc_pkg::IDX_RSVD_LAST)
      |-> dat_o == 32'h0000_0000) else $error("reserved register read nonzero");
  AST_CONV_HIGH: assert property (s_read(tmc_pkg::IDX_CONV_HIGH) ##0 $past(rd_acc)
      |-> dat_o[7:0] == $past(conv_q[9:2])) else $error("high result byte wrong");
  AST_CONV_LOW: assert property (s_read(tmc_pkg::IDX_CONV_LOW) |-> dat_o[7:2] == 6'h00)
    else $error("low result upper bits nonzero");
  AST_LATCH: assert property (ce_i && !raw_q |=> !latched_q)
    else $error("latched lock bit not dropped");
  AST_LATCH_SET: assert property (rd_acc && raw_q && idx == tmc_pkg::IDX_LOCK_STAT |=> latched_q)
    else $error("latched lock bit not restored by read");
  AST_HOLD: assert property (conv_hold_q && ce_i && conv_valid_i && !rd_acc |=> $stable(conv_low_q))
    else $error("held low result bits overwritten");
  AST_SNAP: assert property (rd_acc && idx == tmc_pkg::IDX_CONV_HIGH |=> conv_low_q == $past(conv_q[1:0]))
    else $error("low bits not taken with high byte");
  AST_IRQ_SET: assert property (ce_i && irq_evt[tmc_pkg::IRQ_CONV] |=> irq_stat_q[tmc_pkg::IRQ_CONV])
    else $error("event lost against clear");
endmodule
